// ---- rtl/wps_defines.svh ----
`ifndef WPS_DEFINES_SVH
`define WPS_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define WPS_REG_CTRL 8'h00
`define WPS_REG_START 8'h04
`define WPS_REG_LENGTH 8'h08
`define WPS_REG_REPEAT 8'h0c
`define WPS_REG_MIX 8'h10
`define WPS_REG_CMD 8'h14
`define WPS_REG_STATUS 8'h18
`define WPS_REG_CUR_ADDR 8'h1c
`define WPS_REG_REP_LEFT 8'h20
`define WPS_REG_SEQ_CNT 8'h24
// sequence table window: 0x40 + 8*entry, start then length
`define WPS_SEQ_REGION 2'h1
////////////////////////////////////////////////////////////////////////////////
// control bit positions
`define WPS_CTRL_RUN 0
`define WPS_CTRL_MODE_LO 1
`define WPS_CTRL_MODE_HI 2
`define WPS_CTRL_CH_OE 3
`define WPS_CTRL_MK_OE 4
`define WPS_CTRL_MIX_EN 5
`define WPS_CTRL_SYNC_EN 6
`define WPS_CTRL_SLAVE 7
`define WPS_CTRL_TRIG_NEG 8
`define WPS_CTRL_RGATE 9
`define WPS_CTRL_W 10
// command bit positions
`define WPS_CMD_TRIG 0
`define WPS_CMD_EVENT 1
`define WPS_CMD_JUMP 2
`define WPS_CMD_TGT_LO 4
`define WPS_CMD_TGT_HI 5
////////////////////////////////////////////////////////////////////////////////
// data path and timing
`define WPS_QUARTER_LAST 2'h3
`define WPS_PTS_PER_WORD 3'h4
`define WPS_PT_W 10
`define WPS_SMP_W 8
`define WPS_MIX_FULL 9'h100
// reset values
`define WPS_CTRL_RST 10'h018
`define WPS_REP_RST 16'h0001
`define WPS_MIX_RST 8'h80
`define WPS_SEQ_CNT_RST 3'h1
`endif

// ---- rtl/wps_pkg.sv ----
package wps_pkg;
	typedef enum logic [1:0] {WPS_CONT, WPS_TRIG, WPS_GATE, WPS_ENH} wps_mode_t;
	typedef enum logic {WPS_IDLE, WPS_PLAY} wps_state_t;
endpackage // wps_pkg

// ---- rtl/wps_sequencer.sv ----
// Overview of operation
// - continuous mode loops waveform, ignores triggers
// - triggered mode plays repeat count times per trigger
// - gated mode outputs only while gate true
// - enhanced mode plays programmed segment order
// - remote commands ignored during synchronous operation
// - memory point holds sample plus two markers
// - start loads address and length counters
// - counters step at quarter sample rate
// - in triggered mode a nonzero repeat count plays that many times
// - enhanced mode steps segments on events
// - shift register serialises samples to dac
// - mixing sums weighted points of a, b
// - master supplies trigger, slave follows it
// - output enables live; run clear stops output
`include "wps_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module wps_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	always_ff @(posedge clk) begin
		if (!rst_n || clr) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // wps_fifo

////////////////////////////////////////////////////////////////////////////////
module wps_sequencer import wps_pkg::*; #(
	parameter int ADDR_W = 25,
	parameter int FIFO_DEPTH = 32,
	parameter int SEQ_N = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_trigger_input,
	input wire logic ext_event_input,
	input wire logic force_trigger_btn,
	input wire logic force_event_btn,
	input wire logic sync_trigger_in,
	output logic sync_trigger_out,
	output logic mem_rd,
	output logic [ADDR_W-3:0] mem_addr,
	input wire logic [4*`WPS_PT_W-1:0] mem_data_a,
	input wire logic [4*`WPS_PT_W-1:0] mem_data_b,
	output logic [`WPS_SMP_W-1:0] dac_data,
	output logic dac_valid,
	output logic [1:0] marker_out,
	output logic channel_output_enable,
	output logic marker_output_enable
);
	localparam int WW = 4 * `WPS_PT_W;
	localparam int WA = ADDR_W - 2;

	function automatic logic [WW-1:0] mix_word(input logic [WW-1:0] a,
			input logic [WW-1:0] b, input logic [7:0] r);
		logic [17:0] acc;
		logic [WW-1:0] res;
		res = a;
		for (int i = 0; i < 4; i++) begin
			acc = 18'(a[i*`WPS_PT_W +: 8] * r) +
				18'(b[i*`WPS_PT_W +: 8] * (`WPS_MIX_FULL - {1'b0, r}));
			res[i*`WPS_PT_W +: 8] = acc[15:8];
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers and apb slave
	logic [`WPS_CTRL_W-1:0] ctrl;
	logic [ADDR_W-1:0] start_reg;
	logic [ADDR_W-1:0] len_reg;
	logic [15:0] rep_reg;
	logic [7:0] mix_ratio;
	logic [2:0] seq_cnt;
	logic [ADDR_W-1:0] seq_start [SEQ_N];
	logic [ADDR_W-1:0] seq_len [SEQ_N];
	wps_state_t state;
	logic [WA-1:0] addr_cnt;
	logic [WA-1:0] len_cnt;
	logic [15:0] rep_left;
	logic [1:0] seq_idx;
	logic event_seen;
	logic jump_pend;
	logic [1:0] jump_tgt;
	logic [1:0] phase;
	logic pending;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [WW-1:0] fifo_out_data;
	logic [WW-1:0] sh_data;
	logic [2:0] sh_cnt;

	wire run = ctrl[`WPS_CTRL_RUN];
	wire wps_mode_t mode = wps_mode_t'(ctrl[`WPS_CTRL_MODE_HI:`WPS_CTRL_MODE_LO]);
	wire sync_en = ctrl[`WPS_CTRL_SYNC_EN];
	wire slave = sync_en && ctrl[`WPS_CTRL_SLAVE];
	wire wr_en = psel && penable && pwrite;
	wire seq_hit = paddr[7:6] == `WPS_SEQ_REGION && 32'(paddr[5:3]) < SEQ_N;
	wire [1:0] seq_sel = paddr[4:3];
	wire plain_hit = paddr <= `WPS_REG_SEQ_CNT && paddr[1:0] == 2'h0;
	wire addr_ok = plain_hit || (seq_hit && paddr[1:0] == 2'h0);
	wire cmd_wr = wr_en && paddr == `WPS_REG_CMD;
	wire [31:0] status = {27'h0, !fifo_out_valid, seq_idx, 1'b0,
		state == WPS_PLAY};
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		unique case (paddr)
			`WPS_REG_CTRL: rd_mux = 32'(ctrl);
			`WPS_REG_START: rd_mux = 32'(start_reg);
			`WPS_REG_LENGTH: rd_mux = 32'(len_reg);
			`WPS_REG_REPEAT: rd_mux = 32'(rep_reg);
			`WPS_REG_MIX: rd_mux = 32'(mix_ratio);
			`WPS_REG_STATUS: rd_mux = status;
			`WPS_REG_CUR_ADDR: rd_mux = 32'(addr_cnt);
			`WPS_REG_REP_LEFT: rd_mux = 32'(rep_left);
			`WPS_REG_SEQ_CNT: rd_mux = 32'(seq_cnt);
			default: if (seq_hit)
				rd_mux = paddr[2] ? 32'(seq_len[seq_sel]) : 32'(seq_start[seq_sel]);
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	always_ff @(posedge clk) begin
		if (!rst_n)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl <= `WPS_CTRL_RST;
			start_reg <= '0;
			len_reg <= '0;
			rep_reg <= `WPS_REP_RST;
			mix_ratio <= `WPS_MIX_RST;
			seq_cnt <= `WPS_SEQ_CNT_RST;
			for (int i = 0; i < SEQ_N; i++) begin
				seq_start[i] <= '0;
				seq_len[i] <= '0;
			end
		end else if (wr_en) begin
			unique case (paddr)
				`WPS_REG_CTRL: ctrl <= pwdata[`WPS_CTRL_W-1:0];
				`WPS_REG_START: start_reg <= pwdata[ADDR_W-1:0];
				`WPS_REG_LENGTH: len_reg <= pwdata[ADDR_W-1:0];
				`WPS_REG_REPEAT: rep_reg <= pwdata[15:0];
				`WPS_REG_MIX: mix_ratio <= pwdata[7:0];
				`WPS_REG_SEQ_CNT: seq_cnt <= pwdata[2:0];
				default: if (seq_hit) begin
					if (paddr[2])
						seq_len[seq_sel] <= pwdata[ADDR_W-1:0];
					else
						seq_start[seq_sel] <= pwdata[ADDR_W-1:0];
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and trigger sources
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic [4:0] pin_s3;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
		end else begin
			pin_s1 <= {sync_trigger_in, force_event_btn, ext_event_input,
				force_trigger_btn, external_trigger_input};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end
	wire tneg = ctrl[`WPS_CTRL_TRIG_NEG];
	wire ext_lvl = pin_s2[0] ^ tneg;
	wire ext_rise = ext_lvl && !(pin_s3[0] ^ tneg);
	wire [4:0] pin_rise = pin_s2 & ~pin_s3;
	wire remote_ok = !sync_en;
	wire remote_trig = cmd_wr && pwdata[`WPS_CMD_TRIG] && remote_ok;
	wire remote_event = cmd_wr && pwdata[`WPS_CMD_EVENT] && remote_ok;
	wire remote_jump = cmd_wr && pwdata[`WPS_CMD_JUMP] && remote_ok;
	wire trig_pulse = slave ? pin_rise[4] :
		(ext_rise || pin_rise[1] || remote_trig);
	wire gate = slave ? pin_s2[4] : (ext_lvl || pin_s2[1] ||
		(ctrl[`WPS_CTRL_RGATE] && remote_ok));
	wire event_pulse = pin_rise[2] || pin_rise[3] || remote_event;

	always_ff @(posedge clk) begin
		if (!rst_n)
			sync_trigger_out <= 1'b0;
		else
			sync_trigger_out <= sync_en && !slave &&
				(mode == WPS_GATE ? gate : trig_pulse);
	end

	////////////////////////////////////////////////////////////////////////
	// memory address control
	// quarter rate phase
	always_ff @(posedge clk) begin
		if (!rst_n)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end
	wire qtick = phase == `WPS_QUARTER_LAST;
	wire gate_ok = mode != WPS_GATE || gate;
	wire step = run && state == WPS_PLAY && qtick && fifo_in_ready &&
		!pending && gate_ok;
	wire last = len_cnt == WA'(1);
	wire [1:0] idx_inc = (3'(seq_idx) + 3'h1 >= seq_cnt) ? 2'h0 :
		seq_idx + 2'h1;
	wire [1:0] next_idx = state == WPS_IDLE ? 2'h0 :
		jump_pend ? jump_tgt : event_seen ? idx_inc : seq_idx;
	wire enh = mode == WPS_ENH;
	wire [ADDR_W-1:0] load_addr = enh ? seq_start[next_idx] : start_reg;
	wire [ADDR_W-1:0] load_len = enh ? seq_len[next_idx] : len_reg;
	wire start_cond = mode == WPS_CONT ? 1'b1 :
		mode == WPS_GATE ? gate : trig_pulse;
	wire seg_end = step && last;
	wire consume = enh && seg_end;
	assign mem_rd = step;
	assign mem_addr = addr_cnt;

	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			event_seen <= 1'b0;
			jump_pend <= 1'b0;
			jump_tgt <= 2'h0;
		end else begin
			event_seen <= event_pulse || (event_seen && !consume);
			jump_pend <= remote_jump || (jump_pend && !consume);
			if (remote_jump)
				jump_tgt <= pwdata[`WPS_CMD_TGT_HI:`WPS_CMD_TGT_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			state <= WPS_IDLE;
			addr_cnt <= '0;
			len_cnt <= '0;
			rep_left <= '0;
			seq_idx <= 2'h0;
		end else if (state == WPS_IDLE) begin
			if (start_cond) begin
				state <= WPS_PLAY;
				addr_cnt <= load_addr[ADDR_W-1:2];
				len_cnt <= load_len[ADDR_W-1:2];
				rep_left <= rep_reg;
				seq_idx <= next_idx;
			end
		end else if (seg_end) begin
			addr_cnt <= load_addr[ADDR_W-1:2];
			len_cnt <= load_len[ADDR_W-1:2];
			seq_idx <= next_idx;
			if (mode == WPS_TRIG) begin
				if (rep_left > 16'h1)
					rep_left <= rep_left - 16'h1;
				else
					state <= WPS_IDLE;
			end
		end else if (step) begin
			addr_cnt <= addr_cnt + WA'(1);
			len_cnt <= len_cnt - WA'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			pending <= 1'b0;
		else
			pending <= step;
	end

	////////////////////////////////////////////////////////////////////////
	// sample buffer and serialiser
	// weighted a plus b
	wire [WW-1:0] fetched = ctrl[`WPS_CTRL_MIX_EN] ?
		mix_word(mem_data_a, mem_data_b, mix_ratio) : mem_data_a;
	wire sh_load = sh_cnt <= 3'h1 && gate_ok;
	wps_fifo #(
		.WIDTH(WW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.clr(!run),
		.in_valid(pending && run),
		.in_ready(fifo_in_ready),
		.in_data(fetched),
		.out_valid(fifo_out_valid),
		.out_ready(sh_load),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			sh_data <= '0;
			sh_cnt <= 3'h0;
		end else if (sh_load && fifo_out_valid) begin
			sh_data <= fifo_out_data;
			sh_cnt <= `WPS_PTS_PER_WORD;
		end else if (sh_cnt != 3'h0 && gate_ok) begin
			sh_data <= sh_data >> `WPS_PT_W;
			sh_cnt <= sh_cnt - 3'h1;
		end
	end

	wire emit = run && sh_cnt != 3'h0 && gate_ok;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dac_data <= '0;
			marker_out <= 2'h0;
			dac_valid <= 1'b0;
			channel_output_enable <= 1'b0;
			marker_output_enable <= 1'b0;
		end else begin
			dac_valid <= emit;
			dac_data <= emit && ctrl[`WPS_CTRL_CH_OE] ? sh_data[7:0] : '0;
			marker_out <= emit && ctrl[`WPS_CTRL_MK_OE] ? sh_data[9:8] : 2'h0;
			channel_output_enable <= run && ctrl[`WPS_CTRL_CH_OE];
			marker_output_enable <= run && ctrl[`WPS_CTRL_MK_OE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_cont_start;
		run && mode == WPS_CONT && state == WPS_IDLE |=> state == WPS_PLAY;
	endproperty
	a_cont_start: assert property (p_cont_start)
		else $error("continuous mode did not start");
	property p_trig_wait;
		run && $past(run) && mode == WPS_TRIG && state == WPS_IDLE &&
			!trig_pulse |=> state == WPS_IDLE;
	endproperty
	a_trig_wait: assert property (p_trig_wait)
		else $error("triggered mode started without trigger");
	property p_gate_fetch;
		mode == WPS_GATE && !gate |-> !mem_rd && !emit;
	endproperty
	a_gate_fetch: assert property (p_gate_fetch)
		else $error("output while gate false");
	property p_sync_remote;
		sync_en && cmd_wr && pwdata[`WPS_CMD_EVENT] && !pin_rise[2] &&
			!pin_rise[3] |-> !event_pulse;
	endproperty
	a_sync_remote: assert property (p_sync_remote)
		else $error("remote event taken in sync mode");
	property p_load;
		run && state == WPS_IDLE && start_cond |=>
			addr_cnt == $past(load_addr[ADDR_W-1:2]) &&
			len_cnt == $past(load_len[ADDR_W-1:2]);
	endproperty
	a_load: assert property (p_load)
		else $error("counters not loaded at start");
	property p_quarter;
		mem_rd |-> phase == `WPS_QUARTER_LAST ##1 !mem_rd [*3];
	endproperty
	a_quarter: assert property (p_quarter)
		else $error("fetch faster than quarter rate");
	property p_repeat;
		mode == WPS_TRIG && seg_end && rep_left > 16'h1 |=>
			state == WPS_PLAY && rep_left == $past(rep_left) - 16'h1;
	endproperty
	a_repeat: assert property (p_repeat)
		else $error("repeat count not honoured");
	property p_event_step;
		run && enh && seg_end && event_seen && !jump_pend |=>
			seq_idx == $past(idx_inc);
	endproperty
	a_event_step: assert property (p_event_step)
		else $error("sequence did not advance on event");
	property p_stop;
		!run ##1 !run |=> !dac_valid && !mem_rd;
	endproperty
	a_stop: assert property (p_stop)
		else $error("output continued after run cleared");
	property p_serial;
		run && sh_load && fifo_out_valid && gate_ok |=> sh_cnt == 3'h4;
	endproperty
	a_serial: assert property (p_serial)
		else $error("serialiser did not load four points");

	c_cont: cover property (mode == WPS_CONT && seg_end);
	c_trig_rep: cover property (mode == WPS_TRIG && seg_end &&
		rep_left > 16'h1);
	c_enh_adv: cover property (enh && seg_end && event_seen);
	c_gate: cover property (mode == WPS_GATE && dac_valid ##1 !gate);
endmodule // wps_sequencer

// ---- dv/wps_mem_model.sv ----
////////////////////////////////////////////////////////////////////////////////
// waveform memory: answers a fetch on the cycle after mem_rd
module wps_mem_model (
	input wire logic clk,
	input wire logic mem_rd,
	input wire logic [22:0] mem_addr,
	output logic [39:0] mem_data_a,
	output logic [39:0] mem_data_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [24:0] p;
	initial begin
		mem_data_a = 40'h0;
		mem_data_b = 40'h0;
	end
	always @(posedge clk) begin
		if (mem_rd) begin
			for (int k = 0; k < 4; k++) begin
				p = {mem_addr, 2'(k)};
				mem_data_a[10*k+:10] <= {p[9:8], p[7:0] ^ 8'h5a};
				mem_data_b[10*k+:10] <= {p[9:8], ~p[7:0]};
			end
		end else begin
			// no stale data outside the valid cycle
			mem_data_a <= ~mem_data_a;
			mem_data_b <= ~mem_data_b;
		end
	end
endmodule // wps_mem_model

// ---- dv/wps_sequencer_tb.sv ----
`include "wps_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module wps_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, sync_out, mem_rd, dvalid, ch_oe, mk_oe;
	logic trg = 1'b0;
	logic evt = 1'b0;
	logic ftrg = 1'b0;
	logic [22:0] maddr;
	logic [39:0] mda, mdb;
	logic [7:0] dd;
	logic [1:0] mk;
	logic [7:0] r;
	logic [9:0] got[$];
	int bad_count = 0;
	int checked = 0;
	int seed = 32'h726a;
	int i;
	int st;
	int s1;

	always #2.5 clk = ~clk;

	wps_sequencer u_wps_sequencer (.clk(clk), .rst_n(rst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_trigger_input(trg), .ext_event_input(evt),
		.force_trigger_btn(ftrg), .force_event_btn(1'b0),
		.sync_trigger_in(1'b0), .sync_trigger_out(sync_out), .mem_rd(mem_rd),
		.mem_addr(maddr), .mem_data_a(mda), .mem_data_b(mdb), .dac_data(dd),
		.dac_valid(dvalid), .marker_out(mk), .channel_output_enable(ch_oe),
		.marker_output_enable(mk_oe));

	wps_mem_model u_wps_mem_model (.clk(clk), .mem_rd(mem_rd),
		.mem_addr(maddr), .mem_data_a(mda), .mem_data_b(mdb));

	always @(posedge clk) begin
		if (rst_n && dvalid === 1'b1) begin
			got.push_back({mk, dd});
		end
	end

	////////////////////////////////////////////////////////////////////////
	function logic [9:0] ep(input int p);
		ep = {p[9:8], p[7:0] ^ 8'h5a};
	endfunction

	function logic [9:0] em(input int p, input logic [7:0] w);
		logic [7:0] a;
		logic [7:0] b;
		logic [16:0] s;
		a = p[7:0] ^ 8'h5a;
		b = ~p[7:0];
		s = a * w + b * (9'h100 - {1'b0, w});
		em = {p[9:8], s[15:8]};
	endfunction

	task end_of_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			bad_count++;
			end_of_test();
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(a, 1'b1, d, q, e);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(a, 1'b0, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask

	task waitn(input int n, input int lim);
		int k;
		for (k = 0; k < lim && got.size() < n; k++) @(posedge clk);
		if (k == lim) begin
			bad_count++;
			$display("[FAIL] %0t points %h exp %h", $time, got.size(), n);
			end_of_test();
		end
	endtask

	task go(input logic [31:0] c);
		wr(`WPS_REG_CTRL, 32'h018);
		cyc(10);
		got.delete();
		wr(`WPS_REG_CTRL, c);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(12);
		rst_n <= 1'b1;
		rdc(`WPS_REG_CTRL, 32'h018, 1'b0);
		rdc(`WPS_REG_REPEAT, 32'h1, 1'b0);
		rdc(`WPS_REG_MIX, 32'h80, 1'b0);
		rdc(`WPS_REG_SEQ_CNT, 32'h1, 1'b0);
		rdc(8'h2c, 32'h0, 1'b1);
		chk(ch_oe, 1'b0);
		st = $random(seed) & 32'h0003fff0;
		wr(`WPS_REG_START, st);
		wr(`WPS_REG_LENGTH, 32'd960);
		go(32'h019);
		for (i = 0; i < 40; i++) begin
			trg <= 1'($random(seed));
			cyc(7);
		end
		trg <= 1'b0;
		waitn(970, 5000);
		for (i = 0; i < 970; i++) chk(got[i], ep(st + i % 960));
		chk(ch_oe, 1'b1);
		wr(`WPS_REG_CTRL, 32'h011);
		cyc(8);
		chk(dd, 8'h0);
		chk({ch_oe, mk_oe}, 2'b01);
		wr(`WPS_REG_CTRL, 32'h018);
		cyc(10);
		got.delete();
		cyc(40);
		chk(got.size(), 0);
		wr(`WPS_REG_REPEAT, 32'h2);
		go(32'h01b);
		cyc(40);
		chk(got.size(), 0);
		ftrg <= 1'b1;
		cyc(4);
		ftrg <= 1'b0;
		waitn(1920, 6000);
		cyc(100);
		chk(got.size(), 1920);
		chk(got[1919], ep(st + 959));
		go(32'h05b);
		wr(`WPS_REG_CMD, 32'h1);
		cyc(100);
		chk(got.size(), 0);
		ftrg <= 1'b1;
		for (i = 0; i < 10; i++) begin
			@(posedge clk);
			if (sync_out === 1'b1) break;
		end
		ftrg <= 1'b0;
		chk(sync_out, 1'b1);
		go(32'h01b);
		wr(`WPS_REG_CMD, 32'h1);
		waitn(4, 200);
		chk(got[0], ep(st));
		go(32'h01d);
		cyc(60);
		chk(got.size(), 0);
		trg <= 1'b1;
		waitn(40, 300);
		chk(got[0], ep(st));
		trg <= 1'b0;
		cyc(30);
		got.delete();
		cyc(60);
		chk(got.size(), 0);
		r = 8'($random(seed));
		wr(`WPS_REG_MIX, {24'h0, r});
		go(32'h039);
		waitn(4, 300);
		for (i = 0; i < 4; i++) chk(got[i], em(st + i, r));
		s1 = st + 32'h1000;
		wr(8'h40, st);
		wr(8'h44, 32'd960);
		wr(8'h48, s1);
		wr(8'h4c, 32'd960);
		wr(`WPS_REG_SEQ_CNT, 32'h2);
		go(32'h01f);
		trg <= 1'b1;
		cyc(4);
		trg <= 1'b0;
		waitn(100, 400);
		evt <= 1'b1;
		cyc(4);
		evt <= 1'b0;
		waitn(964, 3000);
		chk(got[0], ep(st));
		chk(got[960], ep(s1));
		end_of_test();
	end
endmodule // wps_sequencer_tb
